// >>> lha_regs.vh
/*
 * lha_regs.vh: register offsets, bit positions, reset values and constants
 * of the link header assist block.
 * Assumes an 8-bit register port with byte-sized addresses.
 */
`ifndef LHA_REGS_VH
`define LHA_REGS_VH

// register offsets
`define LHA_CTRL_ADDR 8'h00
`define LHA_STAT_ADDR 8'h01
`define LHA_MASK_ADDR 8'h02
`define LHA_PRE_ADDR 8'h03
`define LHA_CNT_ADDR 8'h04
`define LHA_TCTL_ADDR 8'h05
`define LHA_CAP_ADDR 8'h06
`define LHA_SCTL_ADDR 8'h07
`define LHA_TXD_ADDR 8'h08

// control register bits
`define LHA_CTRL_ENABLE 0
`define LHA_CTRL_MASTER 1
`define LHA_CTRL_ARM 2
`define LHA_CTRL_ROUTE 3
`define LHA_CTRL_BIE 4
`define LHA_CTRL_SIE 5
`define LHA_CTRL_RESET 8'h00

// timer control register bits
`define LHA_TCTL_START 0

// serial control register bits
`define LHA_SCTL_TXON 0

// status bits; the mask register shares this layout
`define LHA_ST_BRK_DET 0
`define LHA_ST_BRK_GEN 1
`define LHA_ST_SYNC 2
`define LHA_ST_COLL 3

`define LHA_SYNC_BYTE 8'h55
`define LHA_SYNC_EDGES 4'h8

`endif

// >>> lha_top.v
/*
 * lha_top.v: header assist for a single-wire link node. Generates or
 * detects the break, measures the sync field, sends sync and identifier
 * bytes, detects bus collisions and raises one shared interrupt.
 * Assumes a synchronous register port and a receive pin already
 * synchronous to CLK.
 */
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`include "lha_regs.vh"

module lha_top #(
    parameter PRE_W = 8,
    parameter CNT_W = 8
) (
    CLK,
    SRST,
    ADDR,
    WDATA,
    WR,
    RD,
    RDATA,
    RX_PIN,
    TX_PIN,
    SERIAL_RX,
    IRQ
);
    input wire CLK;
    input wire SRST;
    input wire [7:0] ADDR;
    input wire [7:0] WDATA;
    input wire WR;
    input wire RD;
    output reg [7:0] RDATA;
    input wire RX_PIN;
    output reg TX_PIN;
    output reg SERIAL_RX;
    output reg IRQ;

    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_BRK_TX = 6'h02;
    localparam [5:0] S_BRK_RX = 6'h04;
    localparam [5:0] S_SYNC_WAIT = 6'h08;
    localparam [5:0] S_SYNC_MEAS = 6'h10;
    localparam [5:0] S_FRAME = 6'h20;

    reg [5:0] state_q;
    reg [7:0] ctrl_q;
    reg [3:0] stat_q;
    reg [3:0] mask_q;
    reg [PRE_W-1:0] pre_q;
    reg [CNT_W-1:0] cnt_q;
    reg [PRE_W-1:0] pdiv_q;
    reg [CNT_W-1:0] tcnt_q;
    reg [15:0] meas_q;
    reg [15:0] cap_q;
    reg [3:0] edges_q;
    reg tx_on_q;
    reg rx_prev_q;
    reg [7:0] sh_q;
    reg [3:0] bit_q;
    reg [PRE_W-1:0] baud_q;
    reg busy_q;
    reg second_q;
    reg [7:0] id_q;
    reg [CNT_W-1:0] low_q;
    reg [PRE_W-1:0] lpdiv_q;

    wire wr_ctrl = WR && (ADDR == `LHA_CTRL_ADDR);
    wire wr_tctl = WR && (ADDR == `LHA_TCTL_ADDR);
    wire wr_txd = WR && (ADDR == `LHA_TXD_ADDR);
    wire enable = ctrl_q[`LHA_CTRL_ENABLE];
    wire master = ctrl_q[`LHA_CTRL_MASTER];
    wire brk_start = master && wr_tctl && WDATA[`LHA_TCTL_START];
    wire brk_arm = !master && wr_ctrl && WDATA[`LHA_CTRL_ARM];
    wire tick = (pdiv_q == {PRE_W{1'b0}});
    wire underflow = tick && (tcnt_q == {CNT_W{1'b0}});
    wire fall = rx_prev_q && !RX_PIN;
    wire rise = !rx_prev_q && RX_PIN;
    wire baud_tick = (baud_q == {PRE_W{1'b0}});
    // collision checked mid-bit, where the receiver latches data
    wire latch_pt = busy_q && (baud_q == (pre_q >> 1));
    wire low_tick = (lpdiv_q == {PRE_W{1'b0}});
    wire long_low = (state_q == S_FRAME) && !RX_PIN && low_tick && (low_q == {CNT_W{1'b0}});

    reg [3:0] ev;
    always @* begin
        ev = 4'h0;
        ev[`LHA_ST_BRK_GEN] = (state_q == S_BRK_TX) && underflow;
        ev[`LHA_ST_BRK_DET] = ((state_q == S_BRK_RX) && !RX_PIN && underflow) || long_low
            || ((state_q == S_BRK_TX) && underflow);
        ev[`LHA_ST_SYNC] = (state_q == S_SYNC_MEAS) && fall && (edges_q == `LHA_SYNC_EDGES - 4'h1);
        ev[`LHA_ST_COLL] = tx_on_q && latch_pt && (RX_PIN != TX_PIN);
    end

    always @(posedge CLK) begin
        if (SRST) begin
            ctrl_q <= `LHA_CTRL_RESET;
            stat_q <= 4'h0;
            mask_q <= 4'h0;
            pre_q <= {PRE_W{1'b0}};
            cnt_q <= {CNT_W{1'b0}};
            tx_on_q <= 1'b0;
            cap_q <= 16'h0000;
            RDATA <= 8'h00;
            IRQ <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= WDATA;
            end
            if (WR && ADDR == `LHA_MASK_ADDR) begin
                mask_q <= WDATA[3:0];
            end
            if (WR && ADDR == `LHA_PRE_ADDR) begin
                pre_q <= WDATA[PRE_W-1:0];
            end
            if (WR && ADDR == `LHA_CNT_ADDR) begin
                cnt_q <= WDATA[CNT_W-1:0];
            end
            if (WR && ADDR == `LHA_SCTL_ADDR) begin
                tx_on_q <= WDATA[`LHA_SCTL_TXON];
            end
            // set wins over a write-one clear in the same cycle
            stat_q <= (stat_q & ~((WR && ADDR == `LHA_STAT_ADDR) ? WDATA[3:0] : 4'h0)) | ev;
            if (ev[`LHA_ST_SYNC]) begin
                cap_q <= meas_q;
            end
            // break sources respect break enable, sync respects sync enable
            IRQ <= |(stat_q & mask_q
                & {1'b1, ctrl_q[`LHA_CTRL_SIE], ctrl_q[`LHA_CTRL_BIE], ctrl_q[`LHA_CTRL_BIE]});
            RDATA <= 8'h00;
            if (RD) begin
                case (ADDR)
                    `LHA_CTRL_ADDR: RDATA <= ctrl_q;
                    `LHA_STAT_ADDR: RDATA <= {4'h0, stat_q};
                    `LHA_MASK_ADDR: RDATA <= {4'h0, mask_q};
                    `LHA_PRE_ADDR: RDATA <= pre_q;
                    `LHA_CNT_ADDR: RDATA <= cnt_q;
                    `LHA_TCTL_ADDR: RDATA <= {7'h00, busy_q};
                    `LHA_CAP_ADDR: RDATA <= cap_q[15:8] != 8'h00 ? 8'hFF : cap_q[7:0];
                    `LHA_SCTL_ADDR: RDATA <= {7'h00, tx_on_q};
                    default: RDATA <= 8'h00;
                endcase
            end
        end
    end

    // header sequencer with shared interval timer
    always @(posedge CLK) begin
        if (SRST) begin
            state_q <= S_IDLE;
            pdiv_q <= {PRE_W{1'b0}};
            tcnt_q <= {CNT_W{1'b0}};
            meas_q <= 16'h0000;
            edges_q <= 4'h0;
            rx_prev_q <= 1'b1;
            low_q <= {CNT_W{1'b0}};
            lpdiv_q <= {PRE_W{1'b0}};
        end else begin
            rx_prev_q <= RX_PIN;
            if (tick) begin
                pdiv_q <= pre_q;
                tcnt_q <= tcnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
            end else begin
                pdiv_q <= pdiv_q - {{(PRE_W-1){1'b0}}, 1'b1};
            end
            // low-length watchdog for overlong low in a frame
            if (RX_PIN) begin
                low_q <= cnt_q;
                lpdiv_q <= pre_q;
            end else if (low_tick) begin
                lpdiv_q <= pre_q;
                low_q <= low_q - {{(CNT_W-1){1'b0}}, 1'b1};
            end else begin
                lpdiv_q <= lpdiv_q - {{(PRE_W-1){1'b0}}, 1'b1};
            end
            if (!enable) begin
                state_q <= S_IDLE; // disabling or SRST is the only way back to S_IDLE
            end else begin
                case (state_q)
                    S_IDLE: begin
                        pdiv_q <= pre_q;
                        tcnt_q <= cnt_q;
                        if (brk_start) begin
                            state_q <= S_BRK_TX;
                        end else if (brk_arm) begin
                            state_q <= S_BRK_RX;
                        end
                    end
                    S_BRK_TX: begin
                        if (underflow) begin
                            state_q <= S_FRAME;
                        end
                    end
                    S_BRK_RX: begin
                        if (RX_PIN) begin
                            pdiv_q <= pre_q;
                            tcnt_q <= cnt_q;
                        end else if (underflow) begin
                            state_q <= S_SYNC_WAIT;
                        end
                    end
                    S_SYNC_WAIT: begin
                        meas_q <= 16'h0000;
                        edges_q <= 4'h0;
                        if (fall) begin
                            state_q <= S_SYNC_MEAS;
                        end
                    end
                    S_SYNC_MEAS: begin
                        // start bit through bit 6 ends at the fifth falling edge
                        meas_q <= meas_q + 16'h0001;
                        if (fall || rise) begin
                            edges_q <= edges_q + 4'h1;
                        end
                        if (ev[`LHA_ST_SYNC]) begin
                            state_q <= S_FRAME;
                        end
                    end
                    S_FRAME: begin
                        // the next header may follow a frame without a disable
                        pdiv_q <= pre_q;
                        tcnt_q <= cnt_q;
                        if (brk_start) begin
                            state_q <= S_BRK_TX;
                        end else if (brk_arm) begin
                            state_q <= S_BRK_RX;
                        end
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end

    // byte transmitter for sync and identifier; bit time is prescaler+1 clocks
    always @(posedge CLK) begin
        if (SRST) begin
            TX_PIN <= 1'b1;
            SERIAL_RX <= 1'b1;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            baud_q <= {PRE_W{1'b0}};
            busy_q <= 1'b0;
            second_q <= 1'b0;
            id_q <= 8'h00;
        end else begin
            // routing bit gates sync waveform into the serial receiver
            if (state_q == S_SYNC_WAIT || state_q == S_SYNC_MEAS || state_q == S_BRK_RX) begin
                SERIAL_RX <= ctrl_q[`LHA_CTRL_ROUTE] ? RX_PIN : 1'b1;
            end else begin
                SERIAL_RX <= RX_PIN;
            end
            if (wr_txd) begin
                id_q <= WDATA;
            end
            if (state_q == S_BRK_TX) begin
                TX_PIN <= underflow;
                if (underflow) begin
                    busy_q <= 1'b1;
                    second_q <= 1'b0;
                    sh_q <= `LHA_SYNC_BYTE;
                    bit_q <= 4'h0;
                    baud_q <= pre_q;
                end
            end else if (busy_q && enable) begin
                if (baud_tick) begin
                    baud_q <= pre_q;
                    bit_q <= bit_q + 4'h1;
                    if (bit_q == 4'h0) begin
                        TX_PIN <= 1'b0;
                    end else if (bit_q < 4'h9) begin
                        TX_PIN <= sh_q[0];
                        sh_q <= {1'b1, sh_q[7:1]};
                    end else if (bit_q == 4'h9) begin
                        TX_PIN <= 1'b1;
                    end else if (!second_q) begin
                        second_q <= 1'b1; // identifier follows sync
                        sh_q <= id_q;
                        bit_q <= 4'h0;
                    end else begin
                        busy_q <= 1'b0;
                    end
                end else begin
                    baud_q <= baud_q - {{(PRE_W-1){1'b0}}, 1'b1};
                end
            end else begin
                TX_PIN <= 1'b1;
                // disabling abandons a byte in flight so the wire idles high
                busy_q <= 1'b0;
            end
        end
    end
endmodule // lha_top

// >>> lha_properties.sv
/* lha_properties.sv: port checker for lha_top, bound below.
   assumes register writes land at the edge that takes them. */
`timescale 1ns/100ps
`include "lha_regs.vh"
module lha_chk (
    input wire CLK,
    input wire SRST,
    input wire [7:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [7:0] RDATA,
    input wire RX_PIN,
    input wire TX_PIN,
    input wire SERIAL_RX,
    input wire IRQ
);
    reg [7:0] ctrl_q;
    reg [3:0] mask_q;
    always @(posedge CLK) begin
        if (SRST) begin
            ctrl_q <= 8'h00;
            mask_q <= 4'h0;
        end else if (WR && ADDR == `LHA_CTRL_ADDR) begin
            ctrl_q <= WDATA;
        end else if (WR && ADDR == `LHA_MASK_ADDR) begin
            mask_q <= WDATA[3:0];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    property p_rst_idle; $past(SRST) |-> TX_PIN && SERIAL_RX && !IRQ; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs busy after reset");
    property p_rd_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    // the arm bit is a write pulse, so it is left out of the comparison
    property p_ctrl_rd; RD && ADDR == `LHA_CTRL_ADDR |=> (RDATA & 8'h3B) == (ctrl_q & 8'h3B); endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback");
    property p_start_low; WR && ADDR == `LHA_TCTL_ADDR && WDATA[0] && ctrl_q[1:0] == 2'h3 |-> ##[1:2] !TX_PIN;
    endproperty
    a_start_low: assert property (p_start_low) else $error("no break after start");
    property p_tx_idle; !ctrl_q[0] && !$past(ctrl_q[0]) |-> TX_PIN; endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("tx low while disabled");
    property p_irq_mask; IRQ |-> $past(mask_q) != 4'h0; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
    property p_irq_gate; IRQ |-> $past(mask_q[3]) || $past(ctrl_q[4]) || $past(ctrl_q[5]); endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
    property p_route; ctrl_q[3] && $past(ctrl_q[3]) |-> SERIAL_RX == $past(RX_PIN); endproperty
    a_route: assert property (p_route) else $error("receive copy wrong");
    c_break: cover property ($fell(TX_PIN));
    c_irq: cover property ($rose(IRQ));
    c_route: cover property (ctrl_q[3] && !RX_PIN);
endmodule // lha_chk
bind lha_top lha_chk u_chk (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .RX_PIN(RX_PIN), .TX_PIN(TX_PIN), .SERIAL_RX(SERIAL_RX), .IRQ(IRQ));

// >>> lha_node.sv
/* lha_node.sv: far node on the pulled-up single wire.
   assumes the wire is low while either node pulls it low. */
`timescale 1ns/100ps
module lha_node #(
    parameter int BT = 4
) (
    input wire clk,
    input wire tx,
    input wire go,
    input wire jam,
    output wire rx
);
    // lsb first: 13 break bits, delimiter, start, 55h, stop
    reg [23:0] pat_q = 24'h000000;
    reg [4:0] left_q = 5'h00;
    reg [7:0] tick_q = 8'h00;
    // jam pulls low on command to force a collision
    assign rx = tx & !jam & (left_q == 5'h00 | pat_q[0]);
    always @(posedge clk) begin
        if (go) begin
            pat_q <= {1'h1, 8'h55, 1'h0, 1'h1, 13'h0000};
            left_q <= 5'h18;
            tick_q <= 8'(BT - 1);
        end else if (left_q != 5'h00 && tick_q == 8'h00) begin
            pat_q <= pat_q >> 1;
            left_q <= left_q - 5'h01;
            tick_q <= 8'(BT - 1);
        end else if (left_q != 5'h00) begin
            tick_q <= tick_q - 8'h01;
        end
    end
endmodule // lha_node

// >>> lha_tb.sv
/* lha_tb.sv: self-checking bench for lha_top and one far node.
   assumes the register map of lha_regs.vh. */
`timescale 1ns/100ps
`include "lha_regs.vh"
module tb_top;
    logic CLK, SRST, WR, RD, go, jam;
    logic [7:0] ADDR, WDATA, d;
    logic [7:0] al [5] = '{8'h00, 8'h01, 8'h02, 8'h07, 8'h20};
    wire [7:0] RDATA;
    wire RX_PIN, TX_PIN, SERIAL_RX, IRQ;
    int miscompares, compares, cyc, n, k, j;
    lha_top #(.PRE_W(8), .CNT_W(8)) DUT (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .RX_PIN(RX_PIN), .TX_PIN(TX_PIN), .SERIAL_RX(SERIAL_RX), .IRQ(IRQ));
    lha_node #(.BT(4)) u_node (.clk(CLK), .tx(TX_PIN), .go(go), .jam(jam), .rx(RX_PIN));
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    task chk(input [7:0] seen, input [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task wr(input [7:0] a, input [7:0] v);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask
    task rd(input [7:0] a);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(posedge CLK);
        d = RDATA;
    endtask
    task wait_tx(input v);
        n = 0;
        while (TX_PIN !== v && n < 500) begin
            @(posedge CLK);
            n++;
        end
    endtask
    // bit time is prescaler+1 = 4 clocks; sample at mid-bit
    task rx_byte(input [7:0] exp);
        wait_tx(1'b1);
        wait_tx(1'b0);
        repeat (2) @(posedge CLK);
        for (j = 0; j < 8; j++) begin
            repeat (4) @(posedge CLK);
            d[j] = TX_PIN;
        end
        chk(d, exp, "tx byte");
    endtask
    always @(posedge CLK) begin
        cyc++;
        if (cyc > 3000) begin
            miscompares++;
            end_of_test;
        end
    end
    initial begin
        {SRST, WR, RD, go, jam} = 5'h10;
        ADDR = 8'h00;
        WDATA = 8'h00;
        repeat (6) @(posedge CLK);
        SRST <= 1'b0;
        wr(8'h20, 8'hFF);
        for (k = 0; k < 5; k++) begin
            rd(al[k]);
            chk(d, 8'h00, "reset value");
        end
        $display("test reset done");
        wr(`LHA_PRE_ADDR, 8'h03);
        wr(`LHA_CNT_ADDR, 8'h03);
        wr(`LHA_MASK_ADDR, 8'h03);
        for (k = 0; k < 2; k++) begin
            wr(`LHA_TXD_ADDR, 8'hA3 ^ k[7:0]);
            wr(`LHA_CTRL_ADDR, {3'h0, k[0], 4'h3});
            wr(`LHA_TCTL_ADDR, 8'h01);
            wait_tx(1'b0);
            wait_tx(1'b1);
            chk({7'h00, n > 13 && n < 19}, 8'h01, "break length");
            rx_byte(`LHA_SYNC_BYTE);
            rx_byte(8'hA3 ^ k[7:0]);
            rd(`LHA_STAT_ADDR);
            chk(d & 8'h03, 8'h03, "break flag");
            chk({7'h00, IRQ}, {7'h00, k[0]}, "break irq");
            wr(`LHA_STAT_ADDR, 8'h0F);
            rd(`LHA_STAT_ADDR);
            chk(d, 8'h00, "cleared status");
        end
        $display("test master done");
        wr(`LHA_MASK_ADDR, 8'h08);
        for (k = 0; k < 2; k++) begin
            wr(`LHA_SCTL_ADDR, {7'h00, k[0]});
            wr(`LHA_TCTL_ADDR, 8'h01);
            wait_tx(1'b0);
            wait_tx(1'b1);
            wait_tx(1'b0);
            jam <= 1'b1;
            repeat (12) @(posedge CLK);
            jam <= 1'b0;
            repeat (80) @(posedge CLK);
            rd(`LHA_STAT_ADDR);
            chk(d & 8'h08, {4'h0, k[0], 3'h0}, "collision flag");
            chk({7'h00, IRQ}, {7'h00, k[0]}, "collision irq");
            wr(`LHA_STAT_ADDR, 8'h0F);
        end
        // a low longer than the break period inside a frame counts as a break
        jam <= 1'b1;
        repeat (20) @(posedge CLK);
        jam <= 1'b0;
        rd(`LHA_STAT_ADDR);
        chk(d & 8'h01, 8'h01, "long low");
        wr(`LHA_STAT_ADDR, 8'h0F);
        $display("test collision done");
        wr(`LHA_CTRL_ADDR, 8'h00);
        wr(`LHA_PRE_ADDR, 8'h01);
        wr(`LHA_MASK_ADDR, 8'h05);
        for (k = 0; k < 2; k++) begin
            // the armed pass runs with routing off, so the receiver copy is held high
            wr(`LHA_CTRL_ADDR, {4'h3, !k[0], k[0], 2'h1});
            go <= 1'b1;
            @(posedge CLK);
            go <= 1'b0;
            repeat (30) @(posedge CLK);
            chk({7'h00, SERIAL_RX}, {7'h00, k[0]}, "receive copy");
            repeat (80) @(posedge CLK);
            rd(`LHA_STAT_ADDR);
            chk(d & 8'h05, {5'h00, k[0], 1'h0, k[0]}, "slave flags");
            chk({7'h00, IRQ}, {7'h00, k[0]}, "slave irq");
            rd(`LHA_CAP_ADDR);
            if (k == 1)
                chk({7'h00, d > 29 && d < 35}, 8'h01, "sync time");
            wr(`LHA_STAT_ADDR, 8'h0F);
        end
        wr(`LHA_PRE_ADDR, d >> 3);
        wr(`LHA_CTRL_ADDR, 8'h00);
        $display("test slave done");
        end_of_test;
    end
endmodule // tb_top
